// ---- design/eep_device.sv ----
// eeprom end: instruction decoder, array, write-enable latch, busy timer and output control
// Function
// - seven instructions, length set by density, organization
// - sample serial input on serial clock rise
// - output released except read data, status
// - selected after programming, output low busy, high ready
// - a one bit releases status on clock fall
// - start bit, opcode, address, then write data
// - modifying commands need program enable high
// - read sends dummy zero then word msb first
// - read bits change on serial clock rise
// - sequential read increments address, wraps to zero
// - dummy zero only before first word
// - chip select fall starts write store cycle
// - self-timed cycle needs no serial clock
// - write clears location before storing, no erase
// - erase sets the addressed location to ones
// - power-up disables programming until enable command
// - enable latch holds until disable or power loss
// - disable blocks modifying, reads always work
// - erase-all sets whole array to ones
// - write-all stores pattern in every location
// - opcode and extended code encodings
// - host drives unused address bit to defined level
`include "eep_params.svh"
`default_nettype none
module eep_device
    import eep_pkg::*;
#(
    parameter int ADDR_W      = 6,
    parameter bit SEQ_READ    = 1'b1,
    parameter bit HAS_PG      = 1'b1,
    parameter int PROG_CYCLES = `EEP_PROG_CYC
) (
    input  wire logic mclk,
    input  wire logic nrst,
    eep_if.dev        link,
    output logic      busy,
    output logic      write_enabled
);
    localparam int AW1 = ADDR_W + 1;
    localparam int NB  = 2 ** AW1;

    logic [7:0]       mem [NB];
    eep_dst_e         st_reg;
    eep_op_e          op_reg;
    logic             lk_q;
    logic             cs_q;
    logic [4:0]       cnt_reg;
    logic [AW1+1:0]   sr_reg;
    logic [15:0]      data_reg;
    logic [AW1-1:0]   addr_reg;
    logic [15:0]      out_reg;
    logic [4:0]       rd_cnt;
    logic             rd_oe;
    logic             rd_bit;
    logic             wel_reg;
    logic [31:0]      busy_cnt;
    logic             stat_arm;
    logic             stat_on;
    logic             hz_pend;
    logic             lk_rise;
    logic             lk_fall;
    logic             cs_fall;
    logic             cs_rise;
    logic             wrd;
    logic [15:0]      nxt_word;
    logic [4:0]       abits;
    logic [4:0]       dbits;
    logic [AW1+1:0]   full;
    logic [AW1+1:0]   hi;
    logic [1:0]       opc;
    logic [1:0]       ext;
    logic [AW1-1:0]   cmd_addr;
    logic [AW1-1:0]   next_addr;
    logic             prog_op;
    logic             prog_go;

    function automatic logic [15:0] rd_word(input logic [AW1-1:0] a, input logic w);
        logic [AW1-1:0] b;
        b = {a[AW1-2:0], 1'b0};
        if (w) begin
            rd_word = {mem[b | AW1'(1)], mem[b]};
        end else begin
            rd_word = {mem[a], 8'h00};
        end
    endfunction : rd_word

    assign wrd      = link.organization_select;
    assign abits    = wrd ? 5'(ADDR_W) : 5'(AW1);
    assign dbits    = wrd ? `EEP_WORD_BITS : `EEP_BYTE_BITS;
    assign lk_rise  = link.serial_clock_in & ~lk_q;
    assign lk_fall  = ~link.serial_clock_in & lk_q;
    assign cs_fall  = cs_q & ~link.cs;
    assign cs_rise  = link.cs & ~cs_q;
    assign full     = {sr_reg[AW1:0], link.serial_in};
    assign hi       = full >> abits;
    assign opc      = hi[1:0];
    assign ext      = 2'(full >> (abits - 5'h02));
    assign cmd_addr = wrd ? (full[AW1-1:0] & AW1'((1 << ADDR_W) - 1)) : full[AW1-1:0];
    assign next_addr = wrd ? ((addr_reg + AW1'(1)) & AW1'((1 << ADDR_W) - 1)) : addr_reg + AW1'(1);
    assign nxt_word = rd_word(next_addr, wrd);
    assign prog_op  = (op_reg == OP_WRITE) || (op_reg == OP_ERASE) || (op_reg == OP_EALL) || (op_reg == OP_WALL);
    // a finished programming command survives the deselect that launches it
    assign prog_go  = (st_reg == D_WAIT) && cs_fall && prog_op && wel_reg
                      && (link.program_enable_in || !HAS_PG);
    assign busy          = (busy_cnt != 32'h0);
    assign write_enabled = wel_reg;
    assign link.so_oe    = rd_oe | stat_on;
    assign link.so_o     = rd_oe ? rd_bit : ~busy;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lk_q <= 1'b0;
            cs_q <= 1'b0;
        end else begin
            lk_q <= link.serial_clock_in;
            cs_q <= link.cs;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_reg   <= D_IDLE;
            op_reg   <= OP_NONE;
            cnt_reg  <= 5'h00;
            sr_reg   <= '0;
            data_reg <= 16'h0000;
            addr_reg <= '0;
            out_reg  <= 16'h0000;
            rd_cnt   <= 5'h00;
            rd_oe    <= 1'b0;
            rd_bit   <= 1'b0;
            wel_reg  <= 1'b0;
        end else if (!link.cs) begin
            st_reg <= D_IDLE;
            op_reg <= OP_NONE;
            rd_oe  <= 1'b0;
        end else if (lk_rise) begin
            case (st_reg)
                D_IDLE: begin
                    // the status-dismiss one also counts as a start bit when ready
                    if (link.serial_in && !busy) begin
                        st_reg  <= D_CMD;
                        cnt_reg <= 5'h00;
                        sr_reg  <= '0;
                    end
                end
                D_CMD: begin
                    sr_reg  <= full;
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == abits + 5'h01) begin
                        addr_reg <= cmd_addr;
                        cnt_reg  <= 5'h00;
                        st_reg   <= D_WAIT;
                        op_reg   <= OP_NONE;
                        case (opc)
                            `EEP_OPC_READ: begin
                                out_reg <= rd_word(cmd_addr, wrd);
                                rd_cnt  <= dbits;
                                rd_bit  <= 1'b0;
                                rd_oe   <= 1'b1;
                                st_reg  <= D_READ;
                            end
                            `EEP_OPC_WRITE: begin
                                op_reg <= OP_WRITE;
                                st_reg <= D_DATA;
                            end
                            `EEP_OPC_ERASE: op_reg <= OP_ERASE;
                            default: begin
                                case (ext)
                                    `EEP_EXT_EN:   wel_reg <= 1'b1;
                                    `EEP_EXT_DIS:  wel_reg <= 1'b0;
                                    `EEP_EXT_EALL: op_reg  <= OP_EALL;
                                    default: begin
                                        op_reg <= OP_WALL;
                                        st_reg <= D_DATA;
                                    end
                                endcase
                            end
                        endcase
                    end
                end
                D_DATA: begin
                    data_reg <= {data_reg[14:0], link.serial_in};
                    cnt_reg  <= cnt_reg + 5'h01;
                    if (cnt_reg == dbits - 5'h01) begin
                        st_reg <= D_WAIT;
                    end
                end
                D_READ: begin
                    if (rd_cnt != 5'h00) begin
                        rd_bit  <= out_reg[15];
                        out_reg <= {out_reg[14:0], 1'b0};
                        rd_cnt  <= rd_cnt - 5'h01;
                    end else if (SEQ_READ) begin
                        addr_reg <= next_addr;
                        rd_bit   <= nxt_word[15];
                        out_reg  <= {nxt_word[14:0], 1'b0};
                        rd_cnt   <= dbits - 5'h01;
                    end else begin
                        rd_oe  <= 1'b0;
                        st_reg <= D_WAIT;
                    end
                end
                D_WAIT: st_reg <= D_WAIT;
                default: st_reg <= D_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // the addressed location, or the whole array for erase-all and write-all, is written in one cycle; the busy timer then models the cell time
    always_ff @(posedge mclk) begin
        if (prog_go) begin
            for (int i = 0; i < NB; i++) begin
                if (op_reg == OP_EALL) begin
                    mem[i] <= `EEP_ERASED_BYTE;
                end else if (op_reg == OP_WALL) begin
                    mem[i] <= (wrd && i[0]) ? data_reg[15:8] : data_reg[7:0];
                end else if (op_reg == OP_ERASE && (wrd ? (AW1'(i) >> 1) == addr_reg : AW1'(i) == addr_reg)) begin
                    mem[i] <= `EEP_ERASED_BYTE;
                end else if (op_reg == OP_WRITE && (wrd ? (AW1'(i) >> 1) == addr_reg : AW1'(i) == addr_reg)) begin
                    mem[i] <= (wrd && i[0]) ? data_reg[15:8] : data_reg[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_cnt <= 32'h0;
        end else if (prog_go) begin
            busy_cnt <= 32'(PROG_CYCLES);
        end else if (busy) begin
            busy_cnt <= busy_cnt - 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stat_arm <= 1'b0;
            stat_on  <= 1'b0;
            hz_pend  <= 1'b0;
        end else if (prog_go) begin
            stat_arm <= 1'b1;
        end else if (!link.cs) begin
            stat_on <= 1'b0;
            hz_pend <= 1'b0;
        end else if (cs_rise && stat_arm) begin
            stat_on <= 1'b1;
        end else if (stat_on && lk_rise && link.serial_in) begin
            hz_pend <= 1'b1;
        end else if (hz_pend && lk_fall) begin
            stat_on  <= 1'b0;
            stat_arm <= 1'b0;
            hz_pend  <= 1'b0;
        end
    end
endmodule : eep_device
`default_nettype wire

// ---- design/eep_params.svh ----
// timing counts, opcode codes and field sizes of the serial eeprom command port
`ifndef EEP_PARAMS_SVH
`define EEP_PARAMS_SVH
`define EEP_CLK_NS        40
`define EEP_LK_HALF_NS    1000
`define EEP_CS_MIN_NS     1000
`define EEP_SV_NS         1000
`define EEP_PROG_MS       10
`define EEP_LK_HALF_CYC   ((`EEP_LK_HALF_NS + `EEP_CLK_NS - 1) / `EEP_CLK_NS)
`define EEP_CS_MIN_CYC    ((`EEP_CS_MIN_NS + `EEP_CLK_NS - 1) / `EEP_CLK_NS)
`define EEP_SV_CYC        ((`EEP_SV_NS + `EEP_CLK_NS - 1) / `EEP_CLK_NS)
`define EEP_PROG_CYC      ((`EEP_PROG_MS * 1000000 + `EEP_CLK_NS - 1) / `EEP_CLK_NS)
`define EEP_OPC_READ      2'h2
`define EEP_OPC_WRITE     2'h1
`define EEP_OPC_ERASE     2'h3
`define EEP_OPC_EXT       2'h0
`define EEP_EXT_EN        2'h3
`define EEP_EXT_DIS       2'h0
`define EEP_EXT_EALL      2'h2
`define EEP_EXT_WALL      2'h1
`define EEP_WORD_BITS     5'h10
`define EEP_BYTE_BITS     5'h08
`define EEP_ERASED_BYTE   8'hFF
`endif

// ---- design/eep_pkg.sv ----
// types shared by both ends of the serial eeprom link
`default_nettype none
package eep_pkg;
    typedef enum logic [2:0] {
        OP_READ  = 3'h0,
        OP_WRITE = 3'h1,
        OP_ERASE = 3'h2,
        OP_EN    = 3'h3,
        OP_DIS   = 3'h4,
        OP_EALL  = 3'h5,
        OP_WALL  = 3'h6,
        OP_NONE  = 3'h7
    } eep_op_e;
    typedef enum logic [4:0] {
        D_IDLE = 5'h01,
        D_CMD  = 5'h02,
        D_DATA = 5'h04,
        D_READ = 5'h08,
        D_WAIT = 5'h10
    } eep_dst_e;
    typedef enum logic [6:0] {
        H_IDLE  = 7'h01,
        H_SHIFT = 7'h02,
        H_READ  = 7'h04,
        H_DESEL = 7'h08,
        H_POLL  = 7'h10,
        H_DISM  = 7'h20,
        H_END   = 7'h40
    } eep_hst_e;
endpackage : eep_pkg
`default_nettype wire

// ---- design/eep_if.sv ----
// pin-level link between the host controller and the eeprom
`default_nettype none
interface eep_if;
    logic cs;
    logic serial_clock_in;
    logic serial_in;
    logic so_o;
    logic so_oe;
    logic so;
    logic organization_select;
    logic program_enable_in;
    // weak pull-up on the released output line
    assign so = so_oe ? so_o : 1'b1;
    modport dev  (input cs, serial_clock_in, serial_in, organization_select, program_enable_in,
                  output so_o, so_oe);
    modport host (output cs, serial_clock_in, serial_in, organization_select, program_enable_in,
                  input so);
endinterface : eep_if
`default_nettype wire

// ---- design/eep_host.sv ----
// host end: builds instructions, clocks the link, collects read words and polls ready
`include "eep_params.svh"
`default_nettype none
module eep_host
    import eep_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input  wire logic            mclk,
    input  wire logic            nrst,
    eep_if.host                  link,
    input  wire logic            wrd_sel,
    input  wire logic            pg_level,
    input  wire logic            cmd_valid,
    output logic                 cmd_ready,
    input  wire eep_op_e         cmd_op,
    input  wire logic [ADDR_W:0] cmd_addr,
    input  wire logic [15:0]     cmd_data,
    input  wire logic [7:0]      cmd_words,
    output logic                 rsp_valid,
    output logic [15:0]          rsp_data,
    output logic                 done
);
    localparam int AW1 = ADDR_W + 1;
    localparam logic [7:0] HALF = 8'(`EEP_LK_HALF_CYC);
    localparam logic [7:0] CSMIN = 8'(`EEP_CS_MIN_CYC);
    localparam logic [7:0] SV = 8'(`EEP_SV_CYC);

    eep_hst_e     st_reg;
    eep_op_e      op_reg;
    logic         cs_reg;
    logic         lk_reg;
    logic         si_reg;
    logic         wrd_reg;
    logic         pg_reg;
    logic [7:0]   cnt_reg;
    logic [31:0]  tx_reg;
    logic [4:0]   left_reg;
    logic [15:0]  rx_reg;
    logic [4:0]   rxb_reg;
    logic [7:0]   words_reg;
    logic [4:0]   abits;
    logic [4:0]   dbits;
    logic [1:0]   opc;
    logic [AW1-1:0] afield;
    logic         has_data;
    logic [31:0]  hdr;
    logic [31:0]  full;
    logic [4:0]   len;
    logic         tick;

    assign link.cs                  = cs_reg;
    assign link.serial_clock_in     = lk_reg;
    assign link.serial_in           = si_reg;
    assign link.organization_select = wrd_reg;
    assign link.program_enable_in   = pg_reg;
    assign cmd_ready = (st_reg == H_IDLE);
    assign abits = wrd_sel ? 5'(ADDR_W) : 5'(AW1);
    assign dbits = wrd_sel ? `EEP_WORD_BITS : `EEP_BYTE_BITS;
    assign has_data = (cmd_op == OP_WRITE) || (cmd_op == OP_WALL);
    assign tick = (cnt_reg == HALF - 8'h01);

    always_comb begin
        opc    = `EEP_OPC_EXT;
        // unused top address bit is forced to zero, never left undriven
        afield = wrd_sel ? (cmd_addr[AW1-1:0] & AW1'((1 << ADDR_W) - 1)) : cmd_addr[AW1-1:0];
        case (cmd_op)
            OP_READ:  opc = `EEP_OPC_READ;
            OP_WRITE: opc = `EEP_OPC_WRITE;
            OP_ERASE: opc = `EEP_OPC_ERASE;
            OP_EN:    afield = AW1'(`EEP_EXT_EN) << (abits - 5'h02);
            OP_DIS:   afield = AW1'(`EEP_EXT_DIS) << (abits - 5'h02);
            OP_EALL:  afield = AW1'(`EEP_EXT_EALL) << (abits - 5'h02);
            default:  afield = AW1'(`EEP_EXT_WALL) << (abits - 5'h02);
        endcase
        hdr  = (32'h1 << (abits + 5'h02)) | (32'(opc) << abits) | 32'(afield);
        full = has_data ? ((hdr << dbits) | 32'(wrd_sel ? cmd_data : {8'h00, cmd_data[7:0]})) : hdr;
        len  = abits + 5'h03 + (has_data ? dbits : 5'h00);
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_reg    <= H_IDLE;
            op_reg    <= OP_NONE;
            cs_reg    <= 1'b0;
            lk_reg    <= 1'b0;
            si_reg    <= 1'b0;
            wrd_reg   <= 1'b1;
            pg_reg    <= 1'b1;
            cnt_reg   <= 8'h00;
            tx_reg    <= 32'h0;
            left_reg  <= 5'h00;
            rx_reg    <= 16'h0000;
            rxb_reg   <= 5'h00;
            words_reg <= 8'h00;
            rsp_valid <= 1'b0;
            rsp_data  <= 16'h0000;
            done      <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            done      <= 1'b0;
            wrd_reg   <= wrd_sel;
            pg_reg    <= pg_level;
            case (st_reg)
                H_IDLE: begin
                    if (cmd_valid) begin
                        op_reg    <= cmd_op;
                        tx_reg    <= full << (6'd32 - {1'b0, len});
                        si_reg    <= 1'b1;
                        left_reg  <= len;
                        words_reg <= (cmd_words == 8'h00) ? 8'h01 : cmd_words;
                        cs_reg    <= 1'b1;
                        cnt_reg   <= 8'h00;
                        st_reg    <= H_SHIFT;
                    end
                end
                H_SHIFT, H_READ, H_DISM: begin
                    cnt_reg <= tick ? 8'h00 : cnt_reg + 8'h01;
                    if (tick) begin
                        lk_reg <= ~lk_reg;
                    end
                    // all work happens at the falling edge, half a period away from the device's rise
                    if (tick && lk_reg) begin
                        if (st_reg == H_SHIFT) begin
                            tx_reg   <= tx_reg << 1;
                            si_reg   <= tx_reg[30];
                            left_reg <= left_reg - 5'h01;
                            if (left_reg == 5'h01) begin
                                si_reg  <= 1'b0;
                                rxb_reg <= 5'h00;
                                if (op_reg == OP_READ) begin
                                    st_reg <= H_READ;                   // dummy zero skipped here
                                end else begin
                                    cs_reg  <= 1'b0;
                                    cnt_reg <= 8'h00;
                                    st_reg  <= H_DESEL;
                                end
                            end
                        end else if (st_reg == H_READ) begin
                            rx_reg  <= {rx_reg[14:0], link.so};
                            rxb_reg <= rxb_reg + 5'h01;
                            if (rxb_reg == dbits - 5'h01) begin
                                rxb_reg   <= 5'h00;
                                rsp_valid <= 1'b1;
                                rsp_data  <= wrd_sel ? {rx_reg[14:0], link.so} : {8'h00, rx_reg[6:0], link.so};
                                words_reg <= words_reg - 8'h01;
                                if (words_reg == 8'h01) begin
                                    cs_reg  <= 1'b0;
                                    cnt_reg <= 8'h00;
                                    st_reg  <= H_END;
                                end
                            end
                        end else begin
                            // select stays up one cycle so the device sees the release on the clock fall
                            si_reg  <= 1'b0;
                            cnt_reg <= 8'h00;
                            st_reg  <= H_END;
                        end
                    end
                end
                H_DESEL: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == CSMIN - 8'h01) begin
                        cnt_reg <= 8'h00;
                        if (op_reg == OP_EN || op_reg == OP_DIS) begin
                            done   <= 1'b1;
                            st_reg <= H_IDLE;
                        end else begin
                            cs_reg <= 1'b1;
                            st_reg <= H_POLL;
                        end
                    end
                end
                H_POLL: begin
                    if (cnt_reg != SV) begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end else if (link.so) begin
                        si_reg  <= 1'b1;
                        cnt_reg <= 8'h00;
                        st_reg  <= H_DISM;
                    end
                end
                H_END: begin
                    cs_reg  <= 1'b0;
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == CSMIN - 8'h01) begin
                        done   <= 1'b1;
                        st_reg <= H_IDLE;
                    end
                end
                default: st_reg <= H_IDLE;
            endcase
        end
    end
endmodule : eep_host
`default_nettype wire

// ---- verification/eep_link_sva.sv ----
// link checker: pin timing between the host and eeprom ends
`default_nettype none
module eep_link_sva (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cs,
    input wire logic serial_clock_in,
    input wire logic serial_in,
    input wire logic so_o,
    input wire logic so_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////
    property p_oe_sel; so_oe |-> cs || $past(cs); endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("output driven while deselected");
    property p_dummy; $rose(so_oe) && $past(cs, 2) |-> !so_o; endproperty
    a_dummy: assert property (p_dummy) else $error("read did not open with a zero");
    property p_release; $fell(so_oe) |-> !$past(cs) || !$past(serial_clock_in); endproperty
    a_release: assert property (p_release) else $error("output released off a clock fall");
    // status may only climb to ready, so any other change must follow a clock rise
    property p_bit_edge; so_oe && $past(so_oe) && $changed(so_o) |-> $past(serial_clock_in) || so_o; endproperty
    a_bit_edge: assert property (p_bit_edge) else $error("output bit moved off a clock rise");
    property p_si_low; $changed(serial_in) |-> !serial_clock_in; endproperty
    a_si_low: assert property (p_si_low) else $error("input data moved while clock high");
    property p_sk_high; $rose(serial_clock_in) |=> serial_clock_in [*8]; endproperty
    a_sk_high: assert property (p_sk_high) else $error("link clock high phase too short");
    property p_cs_low; $fell(cs) |=> !cs [*8]; endproperty
    a_cs_low: assert property (p_cs_low) else $error("deselect time too short");
    property p_cs_rise; $rose(cs) |-> !serial_clock_in; endproperty
    a_cs_rise: assert property (p_cs_rise) else $error("select raised with clock high");
endmodule : eep_link_sva
`default_nettype wire

// ---- verification/serial_eeprom_command_port_tb.sv ----
// self-checking bench: host and eeprom ends joined over the link
`default_nettype none
module serial_eeprom_command_port_tb import eep_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0, nrst = 1'b0, wrd_sel = 1'b1, pg_level = 1'b1, cmd_valid = 1'b0;
    eep_op_e     cmd_op = OP_NONE;
    logic [6:0]  cmd_addr = 7'h00;
    logic [15:0] cmd_data = 16'h0000;
    logic [7:0]  cmd_words = 8'h01;
    logic        cmd_ready, rsp_valid, done, busy, write_enabled;
    logic [15:0] rsp_data;
    logic [15:0] q[$];
    int          fails = 0, n_checks = 0, cyc = 0;
    eep_if eep_if_i ();
    // short program time keeps the run small
    eep_device #(.PROG_CYCLES(50)) eep_device_i (.mclk(mclk), .nrst(nrst), .link(eep_if_i), .busy(busy),
        .write_enabled(write_enabled));
    eep_host eep_host_i (.mclk(mclk), .nrst(nrst), .link(eep_if_i), .wrd_sel(wrd_sel), .pg_level(pg_level),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_words(cmd_words), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .done(done));
    eep_link_sva eep_link_sva_i (.mclk(mclk), .nrst(nrst), .cs(eep_if_i.cs), .serial_clock_in(eep_if_i.serial_clock_in),
        .serial_in(eep_if_i.serial_in), .so_o(eep_if_i.so_o), .so_oe(eep_if_i.so_oe));
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #20 mclk = ~mclk;
    end
    always @(negedge mclk) if (rsp_valid === 1'b1) q.push_back(rsp_data);
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 100000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic op(input eep_op_e o, input logic [6:0] a, input logic [15:0] d, input logic [7:0] n,
                      input logic [15:0] e0, input logic [15:0] e1);
        int k;
        k = 0;
        q.delete();
        @(posedge mclk);
        cmd_op    <= o;
        cmd_addr  <= a;
        cmd_data  <= d;
        cmd_words <= n;
        cmd_valid <= 1'b1;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        while (done !== 1'b1 && k < 5000) begin
            @(negedge mclk);
            k++;
        end
        if (k == 5000) begin
            fails++;
            report_and_stop();
        end else begin
            if (o == OP_READ) begin
                chk((wrd_sel ? 16'hFFFF : 16'h00FF) & q[0], e0);
                if (n > 8'h01) chk(q[1], e1);
            end
            $display("op %0d at %h done", o, a);
        end
    endtask : op
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        chk({15'h0, write_enabled}, 16'h0000);
        op(OP_EN, 7'h00, 16'h0000, 8'h01, 16'h0000, 16'h0000);
        chk({15'h0, write_enabled}, 16'h0001);
        op(OP_WALL, 7'h00, 16'h5A5A, 8'h01, 16'h0000, 16'h0000);
        op(OP_READ, 7'h3F, 16'h0000, 8'h02, 16'h5A5A, 16'h5A5A);
        op(OP_WRITE, 7'h00, 16'hA5A5, 8'h01, 16'h0000, 16'h0000);
        chk({15'h0, busy}, 16'h0000);
        op(OP_WRITE, 7'h3F, 16'h0102, 8'h01, 16'h0000, 16'h0000);
        op(OP_READ, 7'h3F, 16'h0000, 8'h02, 16'h0102, 16'hA5A5);
        op(OP_ERASE, 7'h3F, 16'h0000, 8'h01, 16'h0000, 16'h0000);
        op(OP_READ, 7'h3F, 16'h0000, 8'h01, 16'hFFFF, 16'h0000);
        op(OP_DIS, 7'h00, 16'h0000, 8'h01, 16'h0000, 16'h0000);
        chk({15'h0, write_enabled}, 16'h0000);
        op(OP_WRITE, 7'h3F, 16'h1234, 8'h01, 16'h0000, 16'h0000);
        op(OP_READ, 7'h3F, 16'h0000, 8'h01, 16'hFFFF, 16'h0000);
        op(OP_EN, 7'h00, 16'h0000, 8'h01, 16'h0000, 16'h0000);
        @(posedge mclk) pg_level <= 1'b0;
        op(OP_WRITE, 7'h00, 16'h0000, 8'h01, 16'h0000, 16'h0000);
        op(OP_READ, 7'h00, 16'h0000, 8'h01, 16'hA5A5, 16'h0000);
        @(posedge mclk) pg_level <= 1'b1;
        op(OP_EALL, 7'h00, 16'h0000, 8'h01, 16'h0000, 16'h0000);
        op(OP_READ, 7'h00, 16'h0000, 8'h01, 16'hFFFF, 16'h0000);
        @(posedge mclk) wrd_sel <= 1'b0;
        op(OP_WRITE, 7'h05, 16'h003C, 8'h01, 16'h0000, 16'h0000);
        op(OP_READ, 7'h05, 16'h0000, 8'h01, 16'h003C, 16'h0000);
        report_and_stop();
    end
endmodule : serial_eeprom_command_port_tb
`default_nettype wire
